// ---- rtl/reset_sequencer.sv ----
/*
 * Reset sequencer and external interrupt pin qualifier with AHB-Lite
 * registers. Assumes one 40 MHz clock, an EMIF clock of a quarter of it,
 * and a single AHB-Lite master with hready = hreadyout.
 */
// Functional notes
// [RQ1] board asserts hardware reset after power-up, low during ramp.
// [RQ2] hardware reset pulse lasts at least 250 us.
// [RQ3] core reference clock runs correctly before reset release.
// [RQ4] with PCI enabled, PCI clock runs 32 periods before release.
// [RQ5] host warm reset repeats reset but keeps latched boot straps; code ignores host warm requests with PCI disabled.
// [RQ6] hardware reset never touches the PCI state machine.
// [RQ7] PCI bus reset affects only the PCI state machine.
// [RQ8] emulation reset behaves exactly like host warm reset; code also takes it with PCI disabled, where host warm is ignored.
// [RQ9] boot straps sampled at reset rise; board holds them valid.
// [RQ10] NMI low and high phases last at least 4 CPU clocks.
// [RQ11] external irq low and high phases last at least 8 CPU clocks.
// [RQ12] Z group floats at reset fall with no clock delay.
// [RQ13] Z group driven 2 to 8 CPU clocks after reset rise.
// [RQ14] EEPROM pins driven low in reset if PCI on, port 2 off.
// [RQ15] EEPROM pins valid within 11 CPU clocks after reset rise.
// [RQ16] EMIF outputs float 2E..3P+4E after fall, valid 16E..8P+20E.
// [RQ17] EMIF clock resynchronised inside the fall and rise windows.
// [RQ18] EMIF clock output floats after 2E, valid by 8P+20E.
// [RQ19] hold ack and bus request follow hold request during reset.
// [RQ20] PCI enable strap is static and always valid.
// [RQ21] each external irq pin has a programmable polarity bit.
// [RQ22] irq pins pass two flops, edges detected on synced value.
module reset_sequencer
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_reset_pin_n,
    input wire logic host_soft_reset,
    input wire logic pci_bus_reset_in_n,
    input wire logic pci_enable_strap,
    input wire logic serial_port2_enable,
    input wire logic [3:0] emif_addr_strap_bits,
    input wire logic endian_strap,
    input wire logic pci_eeprom_autoinit_strap,
    input wire logic host_data5_strap,
    input wire logic hold_request_in,
    input wire logic bus_hold_ack_core,
    input wire logic bus_request_core,
    input wire logic eeprom_cs_core,
    input wire logic eeprom_clk_core,
    input wire logic eeprom_dout_core,
    input wire logic [3:0] external_irq_pin,
    input wire logic nmi_pin,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic core_reset_n,
    output logic pci_sm_reset_n,
    output logic z_group_oe_n,
    output logic emif_z_oe_n,
    output logic emif_clock_out_oe_n,
    output logic emif_clock_resync,
    output logic bus_hold_ack,
    output logic bus_request_out,
    output logic eeprom_chip_select,
    output logic eeprom_serial_clock,
    output logic eeprom_serial_data_out,
    output logic eeprom_oe_n,
    output logic [STRAP_W-1:0] boot_config,
    output logic [3:0] ext_irq_event,
    output logic nmi_event
);
    default clocking cb @(posedge clk); endclocking

    // ********************************
    // reset release and pin synchronisers
    // ********************************
    logic rst_meta_reg;
    logic rst_s_n;
    default disable iff (!rst_s_n);
    logic [SYNC_W-1:0] pins_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_s_n <= rst_meta_reg;
        end
    end

    wire [SYNC_W-1:0] pins_raw = {host_data5_strap, pci_eeprom_autoinit_strap,
        endian_strap, emif_addr_strap_bits, nmi_pin, external_irq_pin,
        hold_request_in, serial_port2_enable, pci_enable_strap,
        pci_bus_reset_in_n, host_soft_reset, hw_reset_pin_n};

    pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_s_n),
        .din(pins_raw),
        .dout(pins_s)
    );

    wire hw_rst_s = pins_s[SY_HW_RST];
    wire pci_rst_s = pins_s[SY_PCI_RST];
    wire pci_en_s = pins_s[SY_PCI_EN];
    wire hold_req_s = pins_s[SY_HOLD_REQ];
    wire [3:0] irq_s = pins_s[SY_IRQ_LSB +: 4];
    wire nmi_s = pins_s[SY_NMI];
    wire [STRAP_W-1:0] strap_s = pins_s[SY_STRAP_LSB +: STRAP_W];
    wire low_mode = pci_en_s & ~pins_s[SY_SP2_EN];

    // ********************************
    // register bus
    // ********************************
    logic [3:0] ext_irq_polarity_reg;
    logic emu_req_reg;
    logic wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] status_word;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic hw_flag_reg;
    logic hw_flag_next;

    wire ahb_take = hsel & htrans[1] & hready;
    wire rd_take = ahb_take & ~hwrite;
    wire wr_pol = wr_pend_reg & (wr_addr_reg == REG_POLARITY_OFS);
    wire wr_ctl = wr_pend_reg & (wr_addr_reg == REG_CONTROL_OFS);
    wire [11:0] rd_ofs = haddr[11:0];
    wire [31:0] rd_word = (rd_ofs == REG_STATUS_OFS) ? status_word :
        (rd_ofs == REG_POLARITY_OFS) ? {28'h0000_000, ext_irq_polarity_reg} :
        32'h0000_0000;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_BOOT_LSB +: STRAP_W] = boot_config;
        status_word[ST_PCI_EN_BIT] = pci_en_s;
        status_word[ST_STATE_LSB +: 2] = state_reg;
        status_word[ST_WARM_BIT] = ~hw_flag_reg;
    end

    // zero wait states: read data registered from the address phase
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata_reg <= 32'h0000_0000;
            ext_irq_polarity_reg <= POLARITY_RESET;
            emu_req_reg <= 1'b0;
        end else begin
            wr_pend_reg <= ahb_take & hwrite;
            wr_addr_reg <= haddr[11:0];
            if (rd_take) begin
                hrdata_reg <= rd_word;
            end
            if (wr_pol) begin
                ext_irq_polarity_reg <= hwdata[3:0];
            end
            emu_req_reg <= wr_ctl & hwdata[CTL_EMU_RESET_BIT]; // RQ8
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ********************************
    // interrupt pin qualification
    // ********************************
    logic [5:0] edge_prev_reg;
    logic [3:0] irq_event_reg;
    logic nmi_event_reg;

    wire [3:0] irq_lvl = irq_s ^ ext_irq_polarity_reg; // RQ21
    wire [5:0] edge_cur = {pins_s[SY_HOST_WARM], nmi_s, irq_lvl};
    wire [5:0] edge_hit = edge_cur & ~edge_prev_reg; // RQ22

    // prev starts high so an idle level is not taken for an edge
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            edge_prev_reg <= EDGE_PREV_RESET;
            irq_event_reg <= 4'h0;
            nmi_event_reg <= 1'b0;
        end else begin
            edge_prev_reg <= edge_cur;
            irq_event_reg <= edge_hit[3:0];
            nmi_event_reg <= edge_hit[4];
        end
    end

    assign ext_irq_event = irq_event_reg;
    assign nmi_event = nmi_event_reg;

    pol_edge_a: assert property (($rose(irq_s[1]) // RQ21
        && !ext_irq_polarity_reg[1] && $stable(ext_irq_polarity_reg))
        |=> ext_irq_event[1])
        else $error("rising edge on active-high irq 1 not reported");
    nmi_detect_a: assert property ($rose(nmi_s) |=> // RQ22
        nmi_event ##1 !nmi_event)
        else $error("nmi edge not reported as one pulse");

    // ********************************
    // reset sequence
    // ********************************
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // a host warm request is honoured only with PCI enabled; an emulation request always is
    wire warm_req = (edge_hit[5] & pci_en_s) | emu_req_reg; // RQ5 RQ8
    wire fall_done = (state_reg == SEQ_FALL) && (cnt_reg == EMIF_FLOAT_LAST);
    wire z_release = (state_reg == SEQ_RISE) && (cnt_reg == Z_VALID_LAST);
    wire rise_done = (state_reg == SEQ_RISE) && (cnt_reg == EMIF_VALID_LAST)
        && hw_rst_s;
    wire strap_take = (state_reg == SEQ_HOLD) && hw_flag_reg && hw_rst_s;
    wire warm_done = !hw_flag_reg && (cnt_reg == WARM_HOLD_LAST);
    wire go_fall = (state_next == SEQ_FALL) && (state_reg != SEQ_FALL);

    always_comb begin
        state_next = state_reg;
        hw_flag_next = hw_flag_reg;
        cnt_next = cnt_reg + 1'b1;
        case (state_reg)
            SEQ_RUN: begin
                cnt_next = '0;
                if (!hw_rst_s) begin
                    state_next = SEQ_FALL;
                    hw_flag_next = 1'b1;
                end else if (warm_req) begin
                    state_next = SEQ_FALL;
                    hw_flag_next = 1'b0;
                end
            end
            SEQ_FALL: begin
                if (!hw_rst_s) begin
                    hw_flag_next = 1'b1;
                end
                if (fall_done) begin
                    state_next = SEQ_HOLD;
                    cnt_next = '0;
                end
            end
            SEQ_HOLD: begin
                if (!hw_rst_s) begin
                    hw_flag_next = 1'b1;
                    cnt_next = '0;
                end else if (hw_flag_reg || warm_done) begin
                    state_next = SEQ_RISE;
                    cnt_next = '0;
                end
            end
            SEQ_RISE: begin
                if (!hw_rst_s) begin
                    state_next = SEQ_FALL;
                    hw_flag_next = 1'b1;
                    cnt_next = '0;
                end else if (rise_done) begin
                    state_next = SEQ_RUN;
                end
            end
            default: begin
                state_next = SEQ_FALL;
                hw_flag_next = 1'b1;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_reg <= SEQ_FALL;
            hw_flag_reg <= 1'b1;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            hw_flag_reg <= hw_flag_next;
            cnt_reg <= cnt_next;
        end
    end

    // ********************************
    // boot straps and PCI state machine reset
    // ********************************
    logic [STRAP_W-1:0] boot_reg;
    logic pci_sm_rst_reg;

    // only a hardware release relatches; warm resets keep the old value
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            boot_reg <= BOOT_RESET;
            pci_sm_rst_reg <= 1'b0;
        end else begin
            if (strap_take) begin
                boot_reg <= strap_s; // RQ9 RQ5
            end
            pci_sm_rst_reg <= pci_rst_s; // RQ6 RQ7
        end
    end

    assign boot_config = boot_reg;
    assign pci_sm_reset_n = pci_sm_rst_reg;

    warm_keeps_boot_a: assert property ((state_reg == SEQ_RUN // RQ5
        && hw_rst_s && warm_req) |=> $stable(boot_reg) [*8])
        else $error("warm reset disturbed latched boot straps");
    strap_latch_a: assert property (strap_take |=> // RQ9
        boot_reg == $past(strap_s))
        else $error("boot straps not latched at reset release");
    pci_sm_own_a: assert property ((!hw_rst_s && pci_rst_s) [*2] // RQ6
        |-> pci_sm_reset_n)
        else $error("hardware reset reached the PCI state machine");
    pci_no_core_a: assert property (($fell(pci_rst_s) && hw_rst_s // RQ7
        && state_reg == SEQ_RUN && !warm_req) |=>
        (core_reset_n && state_reg == SEQ_RUN))
        else $error("PCI bus reset disturbed the core");
    emu_warm_a: assert property ((wr_ctl && hwdata[CTL_EMU_RESET_BIT] // RQ8
        && state_reg == SEQ_RUN && hw_rst_s) |=> ##1
        (state_reg == SEQ_FALL && !hw_flag_reg && !core_reset_n))
        else $error("emulation reset did not start a warm reset");

    // ********************************
    // pin group drive control
    // ********************************
    logic z_drive_reg;
    logic emif_drive_reg;
    logic core_rst_reg;
    logic resync_reg;
    logic hold_ack_reg;
    logic bus_req_reg;
    logic [2:0] eeprom_reg;

    // the reset pin clears the Z and low groups without waiting for a clock
    wire z_arst_n = hw_reset_pin_n & rst_s_n;

    always_ff @(posedge clk or negedge z_arst_n) begin
        if (!z_arst_n) begin
            z_drive_reg <= 1'b0; // RQ12
            eeprom_reg <= 3'h0; // RQ14
        end else begin
            if (go_fall) begin
                z_drive_reg <= 1'b0;
            end else if (z_release) begin
                z_drive_reg <= 1'b1; // RQ13 RQ15
            end
            eeprom_reg <= z_drive_reg ?
                {eeprom_cs_core, eeprom_clk_core, eeprom_dout_core} : 3'h0;
        end
    end

    // EMIF side floats only after 2E, and waits 16E after release
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            emif_drive_reg <= 1'b0;
            core_rst_reg <= 1'b0;
            resync_reg <= 1'b0;
            hold_ack_reg <= 1'b0;
            bus_req_reg <= 1'b0;
        end else begin
            if (fall_done) begin
                emif_drive_reg <= 1'b0; // RQ16 RQ18
            end else if (rise_done) begin
                emif_drive_reg <= 1'b1; // RQ16 RQ18
            end
            if (go_fall) begin
                core_rst_reg <= 1'b0;
            end else if (rise_done) begin
                core_rst_reg <= 1'b1;
            end
            resync_reg <= fall_done | rise_done; // RQ17
            hold_ack_reg <= emif_drive_reg ? bus_hold_ack_core : hold_req_s;
            bus_req_reg <= emif_drive_reg ? bus_request_core : hold_req_s; // RQ19
        end
    end

    assign z_group_oe_n = ~z_drive_reg;
    assign emif_z_oe_n = ~emif_drive_reg;
    assign emif_clock_out_oe_n = ~emif_drive_reg;
    assign core_reset_n = core_rst_reg;
    assign emif_clock_resync = resync_reg;
    assign bus_hold_ack = hold_ack_reg;
    assign bus_request_out = bus_req_reg;
    assign {eeprom_chip_select, eeprom_serial_clock,
        eeprom_serial_data_out} = eeprom_reg;
    assign eeprom_oe_n = ~(z_drive_reg | low_mode); // RQ14

    z_float_a: assert property (!hw_rst_s |-> z_group_oe_n) // RQ12
        else $error("Z group driven while reset pin low");
    z_valid_a: assert property ((state_reg == SEQ_HOLD && hw_flag_reg // RQ13
        && hw_rst_s) |-> ##2 z_group_oe_n ##1 !z_group_oe_n)
        else $error("Z group not driven 2..8 clocks after release");
    low_drive_a: assert property ((state_reg == SEQ_HOLD && low_mode) // RQ14
        |-> (!eeprom_oe_n && !eeprom_chip_select && !eeprom_serial_clock
        && !eeprom_serial_data_out))
        else $error("EEPROM pins not held low in reset");
    low_valid_a: assert property ((state_reg == SEQ_HOLD && hw_flag_reg // RQ15
        && hw_rst_s && !low_mode) |-> ##[1:8] !eeprom_oe_n)
        else $error("EEPROM pins not valid within 11 clocks");
    emif_float_a: assert property ((state_reg == SEQ_RUN && !hw_rst_s // RQ16
        && !emif_z_oe_n) |=> (!emif_z_oe_n) [*8] ##1
        (emif_z_oe_n && emif_clock_out_oe_n))
        else $error("EMIF float outside its window");
    emif_valid_a: assert property ((state_reg == SEQ_HOLD // RQ18
        && hw_flag_reg && hw_rst_s) |-> ##64 emif_clock_out_oe_n ##1
        (!emif_z_oe_n && !emif_clock_out_oe_n && core_reset_n))
        else $error("EMIF not valid 16E after release");
    resync_a: assert property (fall_done |=> emif_clock_resync ##1 // RQ17
        !emif_clock_resync)
        else $error("EMIF clock resync pulse missing");
    hold_follow_a: assert property ((emif_z_oe_n && $past(emif_z_oe_n)) // RQ19
        |-> (bus_hold_ack == $past(hold_req_s)
        && bus_request_out == $past(hold_req_s)))
        else $error("hold outputs do not follow hold request in reset");

    hw_cycle_c: cover property ((state_reg == SEQ_HOLD && hw_flag_reg)
        ##[1:200] rise_done);
    warm_cycle_c: cover property ((state_reg == SEQ_FALL && !hw_flag_reg)
        ##[1:200] rise_done);
    nmi_seen_c: cover property (nmi_event);
    low_mode_c: cover property (state_reg == SEQ_HOLD && low_mode);
endmodule

// ---- rtl/rst_seq_pkg.sv ----
/*
 * Constants, register map and state type of the reset and interrupt-pin
 * sequencer. Assumes a single 40 MHz CPU clock; the EMIF clock period is
 * a fixed multiple of it.
 */
package rst_seq_pkg;
    // ********************************
    // clock figures
    // ********************************
    localparam int CPU_PERIOD_NS = 25;
    localparam int EMIF_DIV = 4;
    localparam int EMIF_PERIOD_NS = CPU_PERIOD_NS * EMIF_DIV;

    // ********************************
    // reset timing, in P and E units
    // ********************************
    localparam int Z_VALID_MIN_P = 2;
    localparam int EMIF_FLOAT_MIN_E = 2;
    localparam int EMIF_VALID_MIN_E = 16;
    localparam int WARM_HOLD_P = 32;

    localparam int CNT_W = 7;
    localparam int Z_VALID_CYC =
        (Z_VALID_MIN_P * CPU_PERIOD_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
    localparam int EMIF_FLOAT_CYC =
        (EMIF_FLOAT_MIN_E * EMIF_PERIOD_NS + CPU_PERIOD_NS - 1)
        / CPU_PERIOD_NS;
    localparam int EMIF_VALID_CYC =
        (EMIF_VALID_MIN_E * EMIF_PERIOD_NS + CPU_PERIOD_NS - 1)
        / CPU_PERIOD_NS;
    localparam logic [CNT_W-1:0] Z_VALID_LAST = CNT_W'(Z_VALID_CYC - 1);
    localparam logic [CNT_W-1:0] EMIF_FLOAT_LAST = CNT_W'(EMIF_FLOAT_CYC - 1);
    localparam logic [CNT_W-1:0] EMIF_VALID_LAST = CNT_W'(EMIF_VALID_CYC - 1);
    localparam logic [CNT_W-1:0] WARM_HOLD_LAST = CNT_W'(WARM_HOLD_P - 1);

    // ********************************
    // register map
    // ********************************
    localparam logic [11:0] REG_STATUS_OFS = 12'h000;
    localparam logic [11:0] REG_CONTROL_OFS = 12'h004;
    localparam logic [11:0] REG_POLARITY_OFS = 12'h008;
    localparam int STRAP_W = 7;
    localparam int ST_BOOT_LSB = 0;
    localparam int ST_PCI_EN_BIT = 7;
    localparam int ST_STATE_LSB = 8;
    localparam int ST_WARM_BIT = 10;
    localparam int CTL_EMU_RESET_BIT = 0;
    localparam logic [3:0] POLARITY_RESET = 4'h0;
    localparam logic [STRAP_W-1:0] BOOT_RESET = 7'h00;

    // ********************************
    // synchroniser vector layout
    // ********************************
    localparam int SY_HW_RST = 0;
    localparam int SY_HOST_WARM = 1;
    localparam int SY_PCI_RST = 2;
    localparam int SY_PCI_EN = 3;
    localparam int SY_SP2_EN = 4;
    localparam int SY_HOLD_REQ = 5;
    localparam int SY_IRQ_LSB = 6;
    localparam int SY_NMI = 10;
    localparam int SY_STRAP_LSB = 11;
    localparam int SYNC_W = 18;
    localparam logic [5:0] EDGE_PREV_RESET = 6'h3F;

    typedef enum logic [1:0] {
        SEQ_RUN = 2'b00,
        SEQ_FALL = 2'b01,
        SEQ_HOLD = 2'b11,
        SEQ_RISE = 2'b10
    } seq_state_t;
endpackage

// ---- rtl/pin_sync.sv ----
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes the reset is already released synchronously to clk.
 */
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // zero reset: active-low reset pins read as asserted until sampled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    assign dout = sync_reg;
endmodule

// ---- dv/board_model.sv ----
/* Board side model: hardware reset source and interrupt sources.
   Assumes its tasks are called just after a rising edge of clk. */
module board_model (
    input wire logic clk,
    output logic hw_reset_pin_n,
    output logic [3:0] external_irq_pin,
    output logic nmi_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // 250 us at the 25 ns clock
    localparam int RESET_WIDTH = 10000;
    initial begin
        hw_reset_pin_n = 1'b0;
        external_irq_pin = 4'h0;
        nmi_pin = 1'b0;
    end
    task automatic hold_reset();
        hw_reset_pin_n <= 1'b0;
        repeat (RESET_WIDTH) @(posedge clk);
        hw_reset_pin_n <= 1'b1;
    endtask
    // nmi toggles along with pin 0; width covers both minimum phases
    task automatic irq_edge(input logic [3:0] pins, input int width);
        external_irq_pin <= external_irq_pin ^ pins;
        nmi_pin <= nmi_pin ^ pins[0];
        repeat (width) @(posedge clk);
    endtask
endmodule

// ---- dv/reset_sequencer_tb.sv ----
/* Self-checking bench of the reset sequencer.
   Assumes the board model drives the reset and interrupt pins. */
module reset_sequencer_tb
    import rst_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, hw_reset_pin_n, host_soft_reset, pci_bus_reset_in_n;
    logic pci_enable_strap, serial_port2_enable, hold_request_in, hsel;
    logic hwrite, hreadyout, hresp, core_reset_n, pci_sm_reset_n, nmi_pin;
    logic z_group_oe_n, emif_z_oe_n, emif_clock_out_oe_n, bus_hold_ack;
    logic bus_request_out, eeprom_chip_select, eeprom_oe_n, nmi_event;
    logic [6:0] strap, boot_config, saved;
    logic [4:0] core_in;
    logic [3:0] external_irq_pin, ext_irq_event, ev_hit;
    logic [1:0] htrans, eep;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int num_errors, checks, ev_total, nmi_cnt, n, fc, zc, ec;
    reset_sequencer reset_sequencer_i (.clk, .rst_n, .hw_reset_pin_n,
        .host_soft_reset, .pci_bus_reset_in_n, .pci_enable_strap,
        .serial_port2_enable, .emif_addr_strap_bits(strap[3:0]),
        .endian_strap(strap[4]), .pci_eeprom_autoinit_strap(strap[5]),
        .host_data5_strap(strap[6]), .hold_request_in,
        .bus_hold_ack_core(core_in[0]), .bus_request_core(core_in[1]),
        .eeprom_cs_core(core_in[2]), .eeprom_clk_core(core_in[3]),
        .eeprom_dout_core(core_in[4]), .external_irq_pin, .nmi_pin, .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .core_reset_n, .pci_sm_reset_n,
        .z_group_oe_n, .emif_z_oe_n, .emif_clock_out_oe_n,
        .emif_clock_resync(), .bus_hold_ack, .bus_request_out,
        .eeprom_chip_select, .eeprom_serial_clock(eep[1]),
        .eeprom_serial_data_out(eep[0]), .eeprom_oe_n, .boot_config,
        .ext_irq_event, .nmi_event);
    board_model board_model_i (.clk, .hw_reset_pin_n, .external_irq_pin,
        .nmi_pin);
    initial begin
        clk = 1'b0;
        // the one clock stands in for the PCI clock and runs long before release
        forever #12.5 clk = ~clk;
    end
    // sampled on the falling edge so the counts never race the main flow
    always @(negedge clk) begin
        ev_hit = ev_hit | ext_irq_event;
        ev_total = ev_total + $countones(ext_irq_event);
        nmi_cnt = nmi_cnt + int'(nmi_event === 1'b1);
    end
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] ofs,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= 32'(ofs);
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_core(input logic lvl, input int lim);
        for (n = 0; n < lim && core_reset_n !== lvl; n++) @(posedge clk);
    endtask
    task automatic warm(input logic emu);
        saved = boot_config;
        strap <= ~saved;
        if (emu) ahb(1'b1, REG_CONTROL_OFS, 32'h0000_0001);
        else host_soft_reset <= 1'b1;
        repeat (4) @(posedge clk);
        host_soft_reset <= 1'b0;
        wait_core(1'b0, 20);
        check("warm_core_low", core_reset_n, 1'b0);
        wait_core(1'b1, 300);
        check("warm_core_high", core_reset_n, 1'b1);
        check("warm_boot", boot_config, saved);
        ahb(1'b0, REG_STATUS_OFS, 32'h0000_0000);
        check("warm_flag", rd[ST_WARM_BIT], 1'b1);
        $display("test warm %0d done", emu);
    endtask
    task automatic stop_test();
        $display("checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        $display("unexpected timeout: expected end, seen hang");
        stop_test();
    end
    initial begin
        {rst_n, host_soft_reset, hold_request_in, hsel, hwrite} = 5'h00;
        {pci_bus_reset_in_n, serial_port2_enable} = 2'b10;
        pci_enable_strap = 1'b1;
        {strap, core_in, htrans} = 14'h1A5C;
        {haddr, hwdata, ev_hit, ev_total, nmi_cnt} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        board_model_i.hold_reset();
        wait_core(1'b1, 150);
        check("boot", boot_config, strap);
        ahb(1'b0, REG_STATUS_OFS, 32'h0000_0000);
        check("status", rd[7:0], {1'b1, strap});
        ahb(1'b0, REG_POLARITY_OFS, 32'h0000_0000);
        check("pol_reset", rd, 32'h0000_0000);
        ahb(1'b1, REG_POLARITY_OFS, 32'h0000_0005);
        ahb(1'b0, REG_POLARITY_OFS, 32'h0000_0000);
        check("pol_rw", rd, 32'h0000_0005);
        ahb(1'b0, 12'h0FC, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        repeat (6) @(posedge clk);
        {ev_hit, ev_total, nmi_cnt} = '0;
        board_model_i.irq_edge(4'hF, 8);
        check("irq_rise", {ev_total[27:0], ev_hit},
              {28'd2, 4'hA});
        board_model_i.irq_edge(4'hF, 8);
        check("irq_fall", {ev_total[27:0], ev_hit},
              {28'd4, 4'hF});
        check("nmi", nmi_cnt, 1);
        $display("test irq done");
        pci_bus_reset_in_n <= 1'b0;
        repeat (5) @(posedge clk);
        check("pci_rst", {pci_sm_reset_n, core_reset_n}, 2'b01);
        pci_bus_reset_in_n <= 1'b1;
        warm(1'b0);
        warm(1'b1);
        strap <= 7'h33;
        fork
            board_model_i.hold_reset();
            begin
                #1;
                check("z_float", z_group_oe_n, 1'b1);
                for (fc = 0; fc < 30 && emif_z_oe_n !== 1'b1; fc++)
                    @(posedge clk);
                check("emif_float", fc >= 8 && fc <= 19, 1'b1);
                hold_request_in <= 1'b1;
                repeat (4) @(posedge clk);
                check("hold", {bus_hold_ack, bus_request_out}, 2'b11);
                check("eeprom_low", {eeprom_oe_n, eeprom_chip_select},
                      2'b00);
                check("pci_kept", pci_sm_reset_n, 1'b1);
                hold_request_in <= 1'b0;
                // port 2 on: the EEPROM pins float with the Z group
                serial_port2_enable <= 1'b1;
                repeat (3) @(posedge clk);
                check("eeprom_z", eeprom_oe_n, 1'b1);
            end
        join
        {zc, ec} = '0;
        for (n = 1; n <= 90; n++) begin
            @(posedge clk);
            if (zc == 0 && z_group_oe_n === 1'b0) zc = n;
            if (ec == 0 && emif_z_oe_n === 1'b0) ec = n;
            if (n == 11) check("eeprom", {eeprom_oe_n, eeprom_chip_select,
                eep}, {1'b0, core_in[2], core_in[3], core_in[4]});
        end
        check("z_drive", zc >= 2 && zc <= 8, 1'b1);
        check("emif_drive", ec >= 64 && ec <= 88, 1'b1);
        check("eclk_drive", emif_clock_out_oe_n, 1'b0);
        check("boot_new", boot_config, 7'h33);
        $display("test hw reset done");
        stop_test();
    end
endmodule
